// ---- src/doc_decoder.sv ----
/*
 * Opcode and condition decoder for a 16-bit fixed-point core. Takes words
 * from the fetch unit, decodes add, logic and branch opcodes, gathers the
 * second word of two-word forms, resolves branch conditions and holds off
 * fetch for the instruction's cycle count.
 * Assumes fetch presents words with a valid/ready handshake and that the
 * datapath flags are stable in the cycle the first word is taken.
 */
`timescale 1ns/1ps

module doc_decoder
    import doc_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr_word,
    input  wire logic        i_acc_zero,
    input  wire logic        i_acc_neg,
    input  wire logic        i_overflow,
    input  wire logic        i_carry,
    input  wire logic        i_test_control_flag,
    input  wire logic        i_branch_input_pin,
    input  wire logic        i_aux_nonzero,
    output logic             o_instr_ready,
    output doc_op_t          o_op,
    output logic [3:0]       o_shift_amount_field,
    output logic [7:0]       o_direct_address_field,
    output logic [15:0]      o_ext_word,
    output logic [1:0]       o_words,
    output logic [2:0]       o_cycles,
    output logic             o_cond_met,
    output logic             o_branch_taken,
    output logic             o_illegal,
    output logic             o_dec_valid
);
    typedef enum logic [1:0] {DOC_S_IDLE, DOC_S_EXT, DOC_S_BUSY} doc_state_t;

    doc_cond_if cif ();
    doc_cond_eval u_cond (.cif(cif));

    doc_state_t  state_q, state_d;
    doc_op_t     op_q, op_d;
    logic [3:0]  shift_q, shift_d;
    logic [7:0]  addr_q, addr_d;
    logic [15:0] ext_q, ext_d;
    logic [1:0]  words_q, words_d;
    logic [2:0]  cycles_q, cycles_d;
    logic [2:0]  cnt_q, cnt_d;
    logic        cond_q, cond_d;
    logic        taken_q, taken_d;
    logic        illegal_q, illegal_d;
    logic        valid_q, valid_d;

    wire [15:0] w = i_instr_word;
    wire is_mag   = doc_match(w, DOC_PAT_MAG, DOC_MSK_FULL);
    wire is_addsh = doc_match(w, DOC_PAT_ADD_SHIFT, DOC_MSK_NIB);
    wire is_addhi = doc_match(w, DOC_PAT_ADD_HIGH, DOC_MSK_BYTE);
    wire is_addsi = doc_match(w, DOC_PAT_ADD_SHORT, DOC_MSK_BYTE);
    wire is_addli = doc_match(w, DOC_PAT_ADD_LONG, DOC_MSK_12);
    wire is_add_with_carry_op  = doc_match(w, DOC_PAT_ADD_CARRY, DOC_MSK_BYTE);
    wire is_addlu = doc_match(w, DOC_PAT_ADD_LOWU, DOC_MSK_BYTE);
    wire is_add_shift_by_temp_op  = doc_match(w, DOC_PAT_ADD_TEMP, DOC_MSK_BYTE);
    wire is_auxa  = doc_match(w, DOC_PAT_AUX_ADD, DOC_MSK_BYTE);
    wire is_andd  = doc_match(w, DOC_PAT_AND_DATA, DOC_MSK_BYTE);
    wire is_andl  = doc_match(w, DOC_PAT_AND_LONG, DOC_MSK_12);
    wire is_andh  = doc_match(w, DOC_PAT_AND_HI16, DOC_MSK_FULL);
    wire is_prod  = doc_match(w, DOC_PAT_PROD_ADD, DOC_MSK_FULL);
    wire is_branch_via_accumulator_op  = doc_match(w, DOC_PAT_BR_ACC, DOC_MSK_FULL);
    wire is_baux  = doc_match(w, DOC_PAT_BR_AUX, DOC_MSK_BYTE);
    wire is_conditional_branch_op  = doc_match(w, DOC_PAT_BR_COND, DOC_MSK_COND);
    wire is_bpin  = is_conditional_branch_op && (w[9:8] == DOC_TP_PIN_LOW);

    // every selector code leaves the other path idle for the printed encodings
    assign cif.two_bit_condition_select = w[DOC_TP_LSB +: 2];
    assign cif.cond_mask                = w[DOC_MASK_LSB +: 4];
    assign cif.cond_state               = w[DOC_STATE_LSB +: 4];
    assign cif.flags                    = {i_acc_zero, i_acc_neg, i_overflow, i_carry};
    assign cif.test_control_flag        = i_test_control_flag;
    assign cif.branch_input_pin         = i_branch_input_pin;

    wire two_word   = is_addli | is_andl | is_andh | is_baux | is_conditional_branch_op;
    wire dec_cond   = is_baux ? i_aux_nonzero : (is_conditional_branch_op ? cif.met : 1'b0);
    wire not_taken_cyc_sel = is_bpin;

    doc_op_t dec_op;
    assign dec_op = is_mag   ? DOC_OP_MAG       : is_addsh ? DOC_OP_ADD_SHIFT :
                    is_addhi ? DOC_OP_ADD_HIGH  : is_addsi ? DOC_OP_ADD_SHORT :
                    is_addli ? DOC_OP_ADD_LONG  : is_add_with_carry_op  ? DOC_OP_ADD_CARRY :
                    is_addlu ? DOC_OP_ADD_LOWU  : is_add_shift_by_temp_op  ? DOC_OP_ADD_TEMP  :
                    is_auxa  ? DOC_OP_AUX_ADD   : is_andd  ? DOC_OP_AND_DATA  :
                    is_andl  ? DOC_OP_AND_LONG  : is_andh  ? DOC_OP_AND_HI16  :
                    is_prod  ? DOC_OP_PROD_ADD  : is_branch_via_accumulator_op  ? DOC_OP_BR_ACC    :
                    is_baux  ? DOC_OP_BR_AUX    : is_conditional_branch_op  ? DOC_OP_BR_COND   :
                    DOC_OP_NONE;

    // taken latency first, not-taken second
    wire [2:0] br_cycles = dec_cond ? DOC_CYC_TAKEN :
                           (not_taken_cyc_sel ? DOC_CYC_PIN_NOT : DOC_CYC_NOT_TAKEN);
    wire [2:0] dec_cycles = (is_baux | is_conditional_branch_op) ? br_cycles :
                            is_branch_via_accumulator_op ? DOC_CYC_BR_ACC :
                            (is_addli | is_andl | is_andh) ? DOC_CYC_TWO :
                            DOC_CYC_ONE;
    // long forms carry the shift in the low nibble, the add-shift form in bits 8-11
    wire [3:0] dec_shift = (is_addli | is_andl) ? w[DOC_SHIFT_LO_LSB +: 4] :
                           is_addsh ? w[DOC_SHIFT_HI_LSB +: 4] :
                           is_andh ? 4'(DOC_AND_HI_SHIFT - 1) : 4'h0;

    assign o_instr_ready = (state_q != DOC_S_BUSY);
    wire take = i_instr_valid && o_instr_ready;

    always_comb begin
        state_d   = state_q;
        op_d      = op_q;
        shift_d   = shift_q;
        addr_d    = addr_q;
        ext_d     = ext_q;
        words_d   = words_q;
        cycles_d  = cycles_q;
        cnt_d     = cnt_q;
        cond_d    = cond_q;
        taken_d   = taken_q;
        illegal_d = illegal_q;
        valid_d   = 1'b0;
        case (state_q)
            DOC_S_IDLE: begin
                if (take) begin
                    op_d      = dec_op;
                    shift_d   = dec_shift;
                    addr_d    = w[7:0];
                    ext_d     = 16'h0000;
                    words_d   = two_word ? DOC_WORDS_TWO : DOC_WORDS_ONE;
                    cycles_d  = dec_cycles;
                    cond_d    = dec_cond;
                    taken_d   = dec_cond | is_branch_via_accumulator_op;
                    illegal_d = (dec_op == DOC_OP_NONE);
                    if (two_word) begin
                        state_d = DOC_S_EXT;
                    end else begin
                        valid_d = 1'b1;
                        cnt_d   = dec_cycles - DOC_CYC_ONE;
                        state_d = (dec_cycles > DOC_CYC_ONE) ? DOC_S_BUSY : DOC_S_IDLE;
                    end
                end
            end
            DOC_S_EXT: begin
                if (take) begin
                    ext_d   = w;
                    valid_d = 1'b1;
                    cnt_d   = cycles_q - DOC_CYC_TWO;
                    state_d = (cycles_q > DOC_CYC_TWO) ? DOC_S_BUSY : DOC_S_IDLE;
                end
            end
            DOC_S_BUSY: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h1) begin
                    state_d = DOC_S_IDLE;
                end
            end
            default: begin
                state_d = DOC_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q   <= DOC_S_IDLE;
            op_q      <= DOC_OP_NONE;
            shift_q   <= 4'h0;
            addr_q    <= 8'h00;
            ext_q     <= 16'h0000;
            words_q   <= 2'h0;
            cycles_q  <= 3'h0;
            cnt_q     <= 3'h0;
            cond_q    <= 1'b0;
            taken_q   <= 1'b0;
            illegal_q <= 1'b0;
            valid_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            op_q      <= op_d;
            shift_q   <= shift_d;
            addr_q    <= addr_d;
            ext_q     <= ext_d;
            words_q   <= words_d;
            cycles_q  <= cycles_d;
            cnt_q     <= cnt_d;
            cond_q    <= cond_d;
            taken_q   <= taken_d;
            illegal_q <= illegal_d;
            valid_q   <= valid_d;
        end
    end

    assign o_op                   = op_q;
    assign o_shift_amount_field   = shift_q;
    assign o_direct_address_field = addr_q;
    assign o_ext_word             = ext_q;
    assign o_words                = words_q;
    assign o_cycles               = cycles_q;
    assign o_cond_met             = cond_q;
    assign o_branch_taken         = taken_q;
    assign o_illegal              = illegal_q;
    assign o_dec_valid            = valid_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_first_word(logic [15:0] pat, logic [15:0] msk);
        take && state_q == DOC_S_IDLE && doc_match(i_instr_word, pat, msk);
    endsequence

    sequence s_second_word;
        take && state_q == DOC_S_EXT;
    endsequence

    sequence s_stall_two;
        !o_instr_ready ##1 !o_instr_ready ##1 o_instr_ready;
    endsequence

    a_mag_single: assert property (s_first_word(DOC_PAT_MAG, DOC_MSK_FULL) |=>
        o_dec_valid && o_op == DOC_OP_MAG && o_cycles == 3'h1 && o_instr_ready)
        else $error("magnitude op not one word one cycle");
    a_add_shift: assert property (s_first_word(DOC_PAT_ADD_SHIFT, DOC_MSK_NIB) |=>
        o_dec_valid && o_shift_amount_field == $past(i_instr_word[11:8]))
        else $error("add shift field wrong");
    a_long_add_two: assert property (s_first_word(DOC_PAT_ADD_LONG, DOC_MSK_12)
        ##[1:8] s_second_word |=> o_dec_valid && o_ext_word == $past(i_instr_word)
        && o_op == DOC_OP_ADD_LONG && o_words == 2'h2)
        else $error("long add second word not captured");
    a_and_hi16_sh: assert property (s_first_word(DOC_PAT_AND_HI16, DOC_MSK_FULL) |=>
        !o_dec_valid && state_q == DOC_S_EXT)
        else $error("and shift 16 did not wait for constant");
    a_branch_via_accumulator_op_stall: assert property (s_first_word(DOC_PAT_BR_ACC, DOC_MSK_FULL) |=>
        o_dec_valid && o_branch_taken && !o_instr_ready ##1 s_stall_two)
        else $error("accumulator branch not four cycles");
    a_branch_aux_nonzero_op_taken: assert property (s_first_word(DOC_PAT_BR_AUX, DOC_MSK_BYTE)
        && i_aux_nonzero |=> o_cycles == 3'h4 && o_cond_met)
        else $error("aux branch taken count wrong");
    a_pin_not: assert property (s_first_word(DOC_PAT_BR_COND, DOC_MSK_FULL)
        && i_branch_input_pin |=> o_cycles == 3'h3 && !o_cond_met)
        else $error("pin branch not-taken count wrong");
    a_tc_set_br: assert property (s_first_word(16'he100, DOC_MSK_FULL)
        |=> o_cond_met == $past(i_test_control_flag))
        else $error("flag-set branch verdict wrong");
    a_cond_mask: assert property (s_first_word(16'he300, DOC_MSK_BYTE) |=>
        o_cond_met == $past(|(i_instr_word[3:0] & ~({i_acc_zero, i_acc_neg, i_overflow,
        i_carry} ^ i_instr_word[7:4]))))
        else $error("mask and state verdict wrong");
    a_busy_exit: assert property (o_dec_valid && o_cycles == 3'h4 && o_words == 2'h2
        |-> s_stall_two)
        else $error("stall length wrong");
    a_add_high: assert property (s_first_word(DOC_PAT_ADD_HIGH, DOC_MSK_BYTE) |=>
        o_dec_valid && o_op == DOC_OP_ADD_HIGH && o_words == 2'h1)
        else $error("add high op wrong");
    a_add_short: assert property (s_first_word(DOC_PAT_ADD_SHORT, DOC_MSK_BYTE) |=>
        o_op == DOC_OP_ADD_SHORT && o_direct_address_field == $past(i_instr_word[7:0]))
        else $error("short immediate add wrong");
    a_add_carry: assert property (s_first_word(DOC_PAT_ADD_CARRY, DOC_MSK_BYTE) |=>
        o_dec_valid && o_op == DOC_OP_ADD_CARRY && o_cycles == 3'h1)
        else $error("add with carry op wrong");
    a_add_lowu: assert property (s_first_word(DOC_PAT_ADD_LOWU, DOC_MSK_BYTE) |=>
        o_dec_valid && o_op == DOC_OP_ADD_LOWU && o_cycles == 3'h1)
        else $error("unsigned low add op wrong");
    a_add_temp: assert property (s_first_word(DOC_PAT_ADD_TEMP, DOC_MSK_BYTE) |=>
        o_dec_valid && o_op == DOC_OP_ADD_TEMP && o_cycles == 3'h1)
        else $error("temp shift add op wrong");
    a_aux_short: assert property (s_first_word(DOC_PAT_AUX_ADD, DOC_MSK_BYTE) |=>
        o_op == DOC_OP_AUX_ADD && o_direct_address_field == $past(i_instr_word[7:0]))
        else $error("aux short add wrong");
    a_and_data: assert property (s_first_word(DOC_PAT_AND_DATA, DOC_MSK_BYTE) |=>
        o_dec_valid && o_op == DOC_OP_AND_DATA && o_words == 2'h1)
        else $error("and data op wrong");
    a_prod_add: assert property (s_first_word(DOC_PAT_PROD_ADD, DOC_MSK_FULL) |=>
        o_dec_valid && o_op == DOC_OP_PROD_ADD && o_cycles == 3'h1)
        else $error("product add op wrong");
    a_branch_aux_nonzero_op_not: assert property (s_first_word(DOC_PAT_BR_AUX, DOC_MSK_BYTE)
        && !i_aux_nonzero |=> o_cycles == 3'h2 && !o_cond_met)
        else $error("aux branch not-taken count wrong");
    a_tc_clr_br: assert property (s_first_word(16'he200, DOC_MSK_FULL)
        |=> o_cond_met == !$past(i_test_control_flag))
        else $error("flag-clear branch verdict wrong");

endmodule : doc_decoder

// ---- src/doc_pkg.sv ----
/*
 * Constants shared by the opcode and condition decoder: opcode patterns and
 * compare masks, field positions, condition selector codes and cycle counts.
 * Assumes 16-bit instruction words and a four-flag condition group.
 */
package doc_pkg;

    // compare masks
    localparam logic [15:0] DOC_MSK_NIB   = 16'hf000;
    localparam logic [15:0] DOC_MSK_BYTE  = 16'hff00;
    localparam logic [15:0] DOC_MSK_12    = 16'hfff0;
    localparam logic [15:0] DOC_MSK_FULL  = 16'hffff;
    localparam logic [15:0] DOC_MSK_COND  = 16'hfc00;

    // opcode patterns
    localparam logic [15:0] DOC_PAT_MAG        = 16'hbe00;
    localparam logic [15:0] DOC_PAT_ADD_SHIFT  = 16'h2000;
    localparam logic [15:0] DOC_PAT_ADD_HIGH   = 16'h6100;
    localparam logic [15:0] DOC_PAT_ADD_SHORT  = 16'hb800;
    localparam logic [15:0] DOC_PAT_ADD_LONG   = 16'hbf90;
    localparam logic [15:0] DOC_PAT_ADD_CARRY  = 16'h6000;
    localparam logic [15:0] DOC_PAT_ADD_LOWU   = 16'h6200;
    localparam logic [15:0] DOC_PAT_ADD_TEMP   = 16'h6300;
    localparam logic [15:0] DOC_PAT_AUX_ADD    = 16'h7800;
    localparam logic [15:0] DOC_PAT_AND_DATA   = 16'h6e00;
    localparam logic [15:0] DOC_PAT_AND_LONG   = 16'hbfb0;
    localparam logic [15:0] DOC_PAT_AND_HI16   = 16'hbe81;
    localparam logic [15:0] DOC_PAT_PROD_ADD   = 16'hbe04;
    localparam logic [15:0] DOC_PAT_BR_ACC     = 16'hbe20;
    localparam logic [15:0] DOC_PAT_BR_AUX     = 16'h7b00;
    localparam logic [15:0] DOC_PAT_BR_COND    = 16'he000;

    // field positions
    localparam int DOC_SHIFT_HI_LSB = 8;
    localparam int DOC_SHIFT_LO_LSB = 0;
    localparam int DOC_TP_LSB       = 8;
    localparam int DOC_STATE_LSB    = 4;
    localparam int DOC_MASK_LSB     = 0;
    localparam int DOC_AND_HI_SHIFT = 16;

    // condition selector codes
    localparam logic [1:0] DOC_TP_PIN_LOW = 2'b00;
    localparam logic [1:0] DOC_TP_TC_SET  = 2'b01;
    localparam logic [1:0] DOC_TP_TC_CLR  = 2'b10;
    localparam logic [1:0] DOC_TP_NONE    = 2'b11;

    // word and cycle counts
    localparam logic [1:0] DOC_WORDS_ONE     = 2'h1;
    localparam logic [1:0] DOC_WORDS_TWO     = 2'h2;
    localparam logic [2:0] DOC_CYC_ONE       = 3'h1;
    localparam logic [2:0] DOC_CYC_TWO       = 3'h2;
    localparam logic [2:0] DOC_CYC_BR_ACC    = 3'h4;
    localparam logic [2:0] DOC_CYC_TAKEN     = 3'h4;
    localparam logic [2:0] DOC_CYC_NOT_TAKEN = 3'h2;
    localparam logic [2:0] DOC_CYC_PIN_NOT   = 3'h3;

    typedef enum logic [4:0] {
        DOC_OP_NONE, DOC_OP_MAG, DOC_OP_ADD_SHIFT, DOC_OP_ADD_HIGH, DOC_OP_ADD_SHORT,
        DOC_OP_ADD_LONG, DOC_OP_ADD_CARRY, DOC_OP_ADD_LOWU, DOC_OP_ADD_TEMP,
        DOC_OP_AUX_ADD, DOC_OP_AND_DATA, DOC_OP_AND_LONG, DOC_OP_AND_HI16,
        DOC_OP_PROD_ADD, DOC_OP_BR_ACC, DOC_OP_BR_AUX, DOC_OP_BR_COND
    } doc_op_t;

    function automatic logic doc_match(input logic [15:0] w, input logic [15:0] pat,
                                       input logic [15:0] msk);
        return (w & msk) == pat;
    endfunction : doc_match

endpackage : doc_pkg

// ---- src/doc_cond_if.sv ----
/*
 * Carries the condition fields and flags from the decoder to the condition
 * evaluator, and the verdict back. Assumes one clock domain.
 */
`timescale 1ns/1ps
interface doc_cond_if;
    logic [1:0] two_bit_condition_select;
    logic [3:0] cond_mask;
    logic [3:0] cond_state;
    logic [3:0] flags;
    logic       test_control_flag;
    logic       branch_input_pin;
    logic       met;

    modport decoder (output two_bit_condition_select, cond_mask, cond_state, flags,
                     test_control_flag, branch_input_pin, input met);
    modport evaluator (input two_bit_condition_select, cond_mask, cond_state, flags,
                       test_control_flag, branch_input_pin, output met);
endinterface : doc_cond_if

// ---- src/doc_cond_eval.sv ----
/*
 * Condition evaluator: turns the selector and the mask-and-state byte into
 * one verdict. Purely combinational; flags are taken as already settled.
 */
`timescale 1ns/1ps
module doc_cond_eval
    import doc_pkg::*;
(
    doc_cond_if.evaluator cif
);
    wire       sel_met;
    wire [3:0] flag_match;
    wire       mask_met;

    // selector: pin low, flag set, flag clear, or nothing
    assign sel_met = (cif.two_bit_condition_select == DOC_TP_PIN_LOW) ? !cif.branch_input_pin :
                     (cif.two_bit_condition_select == DOC_TP_TC_SET)  ? cif.test_control_flag :
                     (cif.two_bit_condition_select == DOC_TP_TC_CLR)  ? !cif.test_control_flag :
                     1'b0;

    // met when any masked flag holds its required state; order zero, negative, overflow, carry
    assign flag_match = ~(cif.flags ^ cif.cond_state);
    assign mask_met   = |(cif.cond_mask & flag_match);
    assign cif.met    = sel_met | mask_met;

endmodule : doc_cond_eval

// ---- verif/doc_fetch_model.sv ----
/*
 * Fetch unit model: hands queued words to the decoder one at a time.
 * Assumes the decoder's ready is stable over the low clock phase.
 */
`timescale 1ns/1ps
module doc_fetch_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_instr_ready,
    output logic             o_instr_valid,
    output logic [15:0]      o_instr_word
);
    logic [15:0] words_q[$];
    int          gap;

    task automatic push(input logic [15:0] w);
        words_q.push_back(w);
    endtask : push

    // word held until a rising edge sees ready; idle bus keeps toggling
    initial begin
        o_instr_valid = 1'b0;
        o_instr_word  = 16'h0000;
        gap           = 0;
        forever begin
            @(negedge i_core_clk);
            if (words_q.size() != 0) begin
                repeat (gap) begin
                    o_instr_valid = 1'b0;
                    o_instr_word  = ~o_instr_word;
                    @(negedge i_core_clk);
                end
                o_instr_word  = words_q.pop_front();
                o_instr_valid = 1'b1;
                while (!i_instr_ready) @(negedge i_core_clk);
                @(posedge i_core_clk);
            end else begin
                o_instr_valid = 1'b0;
                o_instr_word  = ~o_instr_word;
            end
        end
    end
endmodule : doc_fetch_model

// ---- verif/dsp_opcode_and_condition_decoder_tb_top.sv ----
/*
 * Self-checking bench for the opcode and condition decoder.
 * Assumes the fetch model in doc_fetch_model and a 40 MHz core clock.
 */
`timescale 1ns/1ps
module dsp_opcode_and_condition_decoder_tb_top
    import doc_pkg::*;
;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n;
    logic [3:0]  flags;
    logic        tc, pin, aux;
    logic        instr_valid, o_instr_ready, o_cond_met, o_branch_taken;
    logic        o_illegal, o_dec_valid;
    logic [15:0] instr_word, o_ext_word;
    doc_op_t     o_op;
    logic [3:0]  o_shift_amount_field;
    logic [7:0]  o_direct_address_field;
    logic [1:0]  o_words;
    logic [2:0]  o_cycles;
    int          err_total = 0;
    int          num_checks = 0;

    always #12.5 i_core_clk = ~i_core_clk;

    doc_fetch_model fetch (.i_core_clk(i_core_clk), .i_instr_ready(o_instr_ready),
                           .o_instr_valid(instr_valid), .o_instr_word(instr_word));

    doc_decoder dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_instr_valid(instr_valid), .i_instr_word(instr_word), .i_acc_zero(flags[3]),
        .i_acc_neg(flags[2]), .i_overflow(flags[1]), .i_carry(flags[0]),
        .i_test_control_flag(tc), .i_branch_input_pin(pin), .i_aux_nonzero(aux),
        .o_instr_ready(o_instr_ready), .o_op(o_op), .o_shift_amount_field(o_shift_amount_field),
        .o_direct_address_field(o_direct_address_field), .o_ext_word(o_ext_word),
        .o_words(o_words), .o_cycles(o_cycles), .o_cond_met(o_cond_met),
        .o_branch_taken(o_branch_taken), .o_illegal(o_illegal), .o_dec_valid(o_dec_valid));

    // selector verdict ORed with masked flag match
    function automatic logic exp_met(input logic [15:0] w, input logic [3:0] f,
                                     input logic t, input logic p, input logic a);
        logic sel;
        if (w[15:8] == 8'h7b) return a;
        case (w[9:8])
            DOC_TP_PIN_LOW: sel = !p;
            DOC_TP_TC_SET:  sel = t;
            DOC_TP_TC_CLR:  sel = !t;
            default:        sel = 1'b0;
        endcase
        return sel | (|(~(f ^ w[7:4]) & w[3:0]));
    endfunction : exp_met

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    // waits for completion, compares fields, then counts stall cycles
    task automatic collect(input doc_op_t op, input logic [1:0] wd, input logic [2:0] cy,
                           input logic [3:0] sh, input logic [15:0] w0, input logic [15:0] ext);
        int n;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (o_dec_valid !== 1'b1 && n < 40);
        chk("dec_valid", 16'h0001, {15'h0, o_dec_valid});
        chk("op", {11'h0, op}, {11'h0, o_op});
        chk("words", {14'h0, wd}, {14'h0, o_words});
        chk("cycles", {13'h0, cy}, {13'h0, o_cycles});
        chk("shift", {12'h0, sh}, {12'h0, o_shift_amount_field});
        chk("addr", {8'h0, w0[7:0]}, {8'h0, o_direct_address_field});
        chk("ext", ext, o_ext_word);
        chk("illegal", 16'h0000, {15'h0, o_illegal});
        n = 0;
        while (o_instr_ready !== 1'b1 && n < 8) begin
            @(negedge i_core_clk);
            n++;
        end
        chk("stall", {13'h0, cy} - {14'h0, wd}, 16'(n));
    endtask : collect

    task automatic t_reset();
        chk("ready", 16'h0001, {15'h0, o_instr_ready});
        chk("dec_valid", 16'h0000, {15'h0, o_dec_valid});
        chk("op", {11'h0, DOC_OP_NONE}, {11'h0, o_op});
        $display("test reset done");
    endtask : t_reset

    task automatic t_one_word();
        logic [15:0] w [10] = '{16'hbe00, 16'h2a12, 16'h6134, 16'hb8ff, 16'h6000,
                                16'h6200, 16'h6300, 16'h7805, 16'h6e00, 16'hbe04};
        doc_op_t op [10] = '{DOC_OP_MAG, DOC_OP_ADD_SHIFT, DOC_OP_ADD_HIGH, DOC_OP_ADD_SHORT,
                             DOC_OP_ADD_CARRY, DOC_OP_ADD_LOWU, DOC_OP_ADD_TEMP,
                             DOC_OP_AUX_ADD, DOC_OP_AND_DATA, DOC_OP_PROD_ADD};
        for (int i = 0; i < 10; i++) fetch.push(w[i]);
        for (int i = 0; i < 10; i++) begin
            collect(op[i], 2'h1, 3'h1, (w[i][15:12] == 4'h2) ? w[i][11:8] : 4'h0, w[i],
                    16'h0000);
        end
        $display("test one_word done");
    endtask : t_one_word

    task automatic t_two_word();
        logic [15:0] w [3] = '{16'hbf93, 16'hbfb7, 16'hbe81};
        logic [3:0]  sh [3] = '{4'h3, 4'h7, 4'hf};
        doc_op_t     op [3] = '{DOC_OP_ADD_LONG, DOC_OP_AND_LONG, DOC_OP_AND_HI16};
        fetch.gap = 2;
        for (int i = 0; i < 3; i++) begin
            fetch.push(w[i]);
            fetch.push(16'h1234 + 16'(i));
            collect(op[i], 2'h2, 3'h2, sh[i], w[i], 16'h1234 + 16'(i));
        end
        fetch.gap = 0;
        $display("test two_word done");
    endtask : t_two_word

    task automatic t_branch_via_accumulator_op();
        fetch.push(16'hbe20);
        collect(DOC_OP_BR_ACC, 2'h1, 3'h4, 4'h0, 16'hbe20, 16'h0000);
        chk("taken", 16'h0001, {15'h0, o_branch_taken});
        $display("test branch_via_accumulator_op done");
    endtask : t_branch_via_accumulator_op

    task automatic t_branch();
        logic [23:0] c [19] = '{24'he00000, 24'he00004, 24'he1000c, 24'he10004, 24'he20004,
                                24'he2000c, 24'he38c0c, 24'he38c4c, 24'he3040c, 24'he3044c,
                                24'he3cc8c, 24'he3cc0c, 24'he3444c, 24'he3111c, 24'he3011c,
                                24'he3022c, 24'he3020c, 24'h7b0006, 24'h7b0004};
        logic [15:0] w;
        logic        m;
        for (int i = 0; i < 19; i++) begin
            w     = c[i][23:8];
            flags = c[i][7:4];
            tc    = c[i][3];
            pin   = c[i][2];
            aux   = c[i][1];
            m     = exp_met(w, flags, tc, pin, aux);
            fetch.push(w);
            fetch.push(16'h0100 + 16'(i));
            collect((w[15:8] == 8'h7b) ? DOC_OP_BR_AUX : DOC_OP_BR_COND, 2'h2,
                    m ? 3'h4 : ((w == 16'he000) ? 3'h3 : 3'h2), 4'h0, w,
                    16'h0100 + 16'(i));
            chk("cond_met", {15'h0, m}, {15'h0, o_cond_met});
            chk("taken", {15'h0, m}, {15'h0, o_branch_taken});
        end
        $display("test branch done");
    endtask : t_branch

    task automatic t_illegal();
        int n;
        n = 0;
        fetch.push(16'hffff);
        do begin
            @(negedge i_core_clk);
            n++;
        end while (o_illegal !== 1'b1 && n < 8);
        chk("illegal", 16'h0001, {15'h0, o_illegal});
        chk("op", {11'h0, DOC_OP_NONE}, {11'h0, o_op});
        fetch.push(16'hbe00);
        collect(DOC_OP_MAG, 2'h1, 3'h1, 4'h0, 16'hbe00, 16'h0000);
        $display("test illegal done");
    endtask : t_illegal

    task automatic t_mid_reset();
        fetch.push(16'hbf93);
        repeat (3) @(negedge i_core_clk);
        i_rst_n = 1'b0;
        @(negedge i_core_clk);
        t_reset();
        i_rst_n = 1'b1;
        fetch.push(16'hbe00);
        collect(DOC_OP_MAG, 2'h1, 3'h1, 4'h0, 16'hbe00, 16'h0000);
        $display("test mid_reset done");
    endtask : t_mid_reset

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    initial begin
        repeat (4000) @(posedge i_core_clk);
        err_total++;
        $display("watchdog expired");
        close_out();
    end

    initial begin
        i_rst_n = 1'b0;
        flags   = 4'h0;
        tc      = 1'b0;
        pin     = 1'b1;
        aux     = 1'b0;
        repeat (6) @(negedge i_core_clk);
        t_reset();
        i_rst_n = 1'b1;
        t_one_word();
        t_two_word();
        t_branch_via_accumulator_op();
        t_branch();
        t_illegal();
        t_mid_reset();
        close_out();
    end
endmodule : dsp_opcode_and_condition_decoder_tb_top
